// ==== src/therm_limit_fan_pulse_config.sv ====
// Purpose: thermal-event duration limit, fan pulse counts and pin-function configuration
// Assumes: one clock, synchronous active-low reset, thermal inputs are active-low pins
// Notes:   registers reached over a plain strobe port, read data one cycle after the strobe
//
// Operation
// R01 - eight-bit duration limit, 22.76 ms per step, 45.52 ms up to 5.82 s
// R02 - assertion time beyond limit sets bit 5 of status register two at 0x42
// R03 - limit zero raises the event as soon as the thermal input asserts
// R04 - per-fan two-bit code selects one to four tach pulses, default two
// R05 - fan fields sit at bits 1:0, 3:2, 5:4 and 7:6
// R06 - pin bit 0 set turns shared 2.5 V pin into the alert output
// R07 - pin bit 1 set turns shared 5 V pin into the thermal input
// R08 - 5 V pin monitored only with pin select and enable bit both set
// R09 - pin bits 3:2 select tach threshold 20, 40, 80 or 130 mV
// R10 - host must not write the two read-only test registers
// R11 - pin bits 7:4 and test registers read zero, writes ignored
// R12 - running eight-bit assertion count is compared with the limit
// R13 - config three enable bit switches monitoring on for the selected pin
// R14 - timer bit 0 set on assertion, cleared on read, lsb after 45.52 ms
// R15 - mask two bit 5 suppresses the alert for the duration event
module therm_limit_fan_pulse_config #(
    parameter int unsigned STEP_CYCLES = therm_cfg_pkg::STEP_CYCLES  // cycles per count
) (
    input  wire logic       clk,           // 25 MHz clock
    input  wire logic       rst_n,         // synchronous reset, active low
    input  wire logic [7:0] addr,          // register address
    input  wire logic [7:0] wdata,         // write data
    input  wire logic       wr,            // write strobe
    input  wire logic       rd,            // read strobe
    output logic      [7:0] rdata,         // read data, cycle after rd
    input  wire logic       therm_5v_n,    // shared 5 V pin as thermal input
    input  wire logic       tach4_n,       // fan 4 tach pin as thermal input
    output logic            irq,           // level interrupt
    output logic            alert_oe,      // open-drain alert, pulls low when high
    output logic      [7:0] pulse_sel,     // fan pulse fields
    output logic      [1:0] tach_thresh,   // 2-wire tach threshold code
    output logic            meas_2v5_en,   // 2.5 V pin used as measurement input
    output logic            meas_5v_en     // 5 V pin used as measurement input
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0]                  limit_q, limit_d;
    logic [7:0]                  pulse_q, pulse_d;
    logic [7:0]                  pin_q, pin_d;
    logic [7:0]                  cfg3_q, cfg3_d;
    logic [7:0]                  mask_q, mask_d;
    logic [7:0]                  status_q, status_d;
    logic [7:0]                  rdata_q, rdata_d;
    logic                        irq_q, irq_d;
    logic                        alert_q, alert_d;
    logic                        meas_2v5_q, meas_2v5_d;
    logic                        meas_5v_q, meas_5v_d;
    logic [1:0]                  meta_q, sync_q;
    logic                        active_q, active_d;
    logic                        flag_q, flag_d;
    logic                        fired_q, fired_d;
    logic [7:0]                  cnt_q, cnt_d;
    logic [therm_cfg_pkg::TICK_W-1:0] tick_q, tick_d;
    logic                        mon_en;
    logic                        pin_asserted;
    logic                        rise;
    logic                        evt;
    logic                        step_done;
    logic                        timer_rd;

    // ------------------------------------------------------------------
    // register read mux
    // ------------------------------------------------------------------
    // test registers and unmapped addresses fall to zero
    function automatic logic [7:0] read_mux(input logic [7:0] a);
        unique case (a)
            therm_cfg_pkg::OFS_IRQ_STATUS2:  read_mux = status_q;
            therm_cfg_pkg::OFS_IRQ_MASK2:    read_mux = mask_q;
            therm_cfg_pkg::OFS_CONFIG3:      read_mux = cfg3_q;
            therm_cfg_pkg::OFS_TIMER_STATUS:
                read_mux = {cnt_q[7:1], (cnt_q >= therm_cfg_pkg::MIN_REPORT) ? cnt_q[0] : flag_q};
            therm_cfg_pkg::OFS_DUR_LIMIT:    read_mux = limit_q;
            therm_cfg_pkg::OFS_PULSE_SEL:    read_mux = pulse_q;
            therm_cfg_pkg::OFS_PIN_CFG:      read_mux = pin_q;  // see R11
            default:                         read_mux = therm_cfg_pkg::RST_ZERO;  // see R11
        endcase
    endfunction

    // ------------------------------------------------------------------
    // thermal monitor
    // ------------------------------------------------------------------
    // monitor needs the enable bit; pin select picks 5 V pin or tach 4
    always_comb begin
        mon_en       = cfg3_q[therm_cfg_pkg::THERM_EN_BIT];  // see R13
        pin_asserted = pin_q[therm_cfg_pkg::THERM_SEL_BIT] ? !sync_q[0] : !sync_q[1];  // see R07
        active_d     = mon_en && pin_asserted;  // see R08
        rise         = active_q && !fired_q && (cnt_q == therm_cfg_pkg::RST_ZERO) && (tick_q == '0);
        step_done    = (32'(tick_q) == STEP_CYCLES - 1);  // see R01
        timer_rd     = rd && (addr == therm_cfg_pkg::OFS_TIMER_STATUS);
        tick_d       = tick_q;
        cnt_d        = cnt_q;
        fired_d      = fired_q;
        evt          = 1'b0;
        if (active_q) begin
            tick_d = step_done ? '0 : tick_q + 1'b1;
            // saturate at full scale rather than wrap to a short time
            if (step_done && cnt_q != 8'hff) begin
                cnt_d = cnt_q + 8'h01;  // see R01
            end
            if (!fired_q) begin
                if (limit_q == therm_cfg_pkg::RST_ZERO) begin
                    evt = 1'b1;  // see R03
                end else if (cnt_q > limit_q) begin
                    evt = 1'b1;  // see R12
                end
            end
            if (evt) begin
                fired_d = 1'b1;
            end
        end else begin
            tick_d  = '0;
            fired_d = 1'b0;
        end
        if (timer_rd) begin
            cnt_d = therm_cfg_pkg::RST_ZERO;
        end
        // set wins over the clear on read
        flag_d = (flag_q && !timer_rd) || rise;  // see R14
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q   <= 2'h3;
            sync_q   <= 2'h3;
            active_q <= 1'b0;
            tick_q   <= '0;
            cnt_q    <= therm_cfg_pkg::RST_ZERO;
            fired_q  <= 1'b0;
            flag_q   <= 1'b0;
        end else begin
            meta_q   <= {tach4_n, therm_5v_n};
            sync_q   <= meta_q;
            active_q <= active_d;
            tick_q   <= tick_d;
            cnt_q    <= cnt_d;
            fired_q  <= fired_d;
            flag_q   <= flag_d;
        end
    end

    // ------------------------------------------------------------------
    // register file and interrupt
    // ------------------------------------------------------------------
    // writes to test registers and reserved pin bits are dropped
    always_comb begin
        limit_d  = limit_q;
        pulse_d  = pulse_q;
        pin_d    = pin_q;
        cfg3_d   = cfg3_q;
        mask_d   = mask_q;
        status_d = status_q;
        rdata_d  = therm_cfg_pkg::RST_ZERO;
        if (wr) begin
            unique case (addr)
                therm_cfg_pkg::OFS_DUR_LIMIT:   limit_d = wdata;  // see R01
                therm_cfg_pkg::OFS_PULSE_SEL:   pulse_d = wdata;  // see R05
                therm_cfg_pkg::OFS_PIN_CFG:     pin_d   = wdata & therm_cfg_pkg::PIN_CFG_WMASK;  // see R11
                therm_cfg_pkg::OFS_CONFIG3:     cfg3_d  = wdata;
                therm_cfg_pkg::OFS_IRQ_MASK2:   mask_d  = wdata;
                therm_cfg_pkg::OFS_IRQ_STATUS2: status_d = status_q & ~wdata;
                default:                        limit_d = limit_q;
            endcase
        end
        if (rd) begin
            rdata_d = read_mux(addr);
        end
        // event after the write-one clear so that set wins
        if (evt) begin
            status_d[therm_cfg_pkg::TIMER_EVT_BIT] = 1'b1;  // see R02
        end
        irq_d   = |(status_q & ~mask_q);  // see R15
        // alert drives only while the shared pin is configured as alert
        alert_d = irq_d && pin_q[therm_cfg_pkg::ALERT_SEL_BIT];  // see R06
        // measurement enables follow the pin bits in step, but leave from flops
        meas_2v5_d = !pin_d[therm_cfg_pkg::ALERT_SEL_BIT];  // see R06
        meas_5v_d  = !pin_d[therm_cfg_pkg::THERM_SEL_BIT];  // see R07
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            limit_q  <= therm_cfg_pkg::RST_DUR_LIMIT;
            pulse_q  <= therm_cfg_pkg::RST_PULSE_SEL;
            pin_q    <= therm_cfg_pkg::RST_PIN_CFG;
            cfg3_q   <= therm_cfg_pkg::RST_CONFIG3;
            mask_q   <= therm_cfg_pkg::RST_MASK2;
            status_q <= therm_cfg_pkg::RST_ZERO;
            rdata_q  <= therm_cfg_pkg::RST_ZERO;
            irq_q    <= 1'b0;
            alert_q  <= 1'b0;
            meas_2v5_q <= !therm_cfg_pkg::RST_PIN_CFG[therm_cfg_pkg::ALERT_SEL_BIT];
            meas_5v_q  <= !therm_cfg_pkg::RST_PIN_CFG[therm_cfg_pkg::THERM_SEL_BIT];
        end else begin
            limit_q  <= limit_d;
            pulse_q  <= pulse_d;
            pin_q    <= pin_d;
            cfg3_q   <= cfg3_d;
            mask_q   <= mask_d;
            status_q <= status_d;
            rdata_q  <= rdata_d;
            irq_q    <= irq_d;
            alert_q  <= alert_d;
            meas_2v5_q <= meas_2v5_d;
            meas_5v_q  <= meas_5v_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // all come straight from flops; pulse fields decode as code plus one
    assign rdata       = rdata_q;
    assign irq         = irq_q;
    assign alert_oe    = alert_q;
    assign pulse_sel   = pulse_q;  // see R04
    assign tach_thresh = pin_q[therm_cfg_pkg::THRESH_LSB +: 2];  // see R09
    assign meas_2v5_en = meas_2v5_q;
    assign meas_5v_en  = meas_5v_q;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_zero_limit_event: assert property (@(posedge clk) disable iff (!rst_n) // see R03
        active_q && !fired_q && limit_q == 8'h00 |=> status_q[5])
        else $error("zero limit did not raise event at once");

    a_exceed_event: assert property (@(posedge clk) disable iff (!rst_n) // see R02
        active_q && !fired_q && limit_q != 8'h00 && cnt_q > limit_q |=> status_q[5])
        else $error("limit exceeded without status bit 5");

    a_status_sticky: assert property (@(posedge clk) disable iff (!rst_n) // see R02
        status_q[5] && !(wr && addr == 8'h42 && wdata[5]) |=> status_q[5])
        else $error("status bit 5 dropped without clear");

    a_test_reads_zero: assert property (@(posedge clk) disable iff (!rst_n) // see R11
        rd && (addr == 8'h7e || addr == 8'h7f) |=> rdata == 8'h00)
        else $error("test register read nonzero");

    a_pin_upper_zero: assert property (@(posedge clk) disable iff (!rst_n) // see R11
        pin_q[7:4] == 4'h0)
        else $error("reserved pin bits set");

    a_monitor_gate: assert property (@(posedge clk) disable iff (!rst_n) // see R08
        !cfg3_q[1] |=> !active_q ##1 cnt_q == $past(cnt_q) || $past(timer_rd))
        else $error("monitoring ran while disabled");

    a_assert_flag: assert property (@(posedge clk) disable iff (!rst_n) // see R14
        rise |=> flag_q)
        else $error("assertion flag not set");

    a_mask_blocks_irq: assert property (@(posedge clk) disable iff (!rst_n) // see R15
        (status_q & ~mask_q) == 8'h00 |=> !irq_q && !alert_oe)
        else $error("interrupt raised while masked");

    a_alert_follows: assert property (@(posedge clk) disable iff (!rst_n) // see R06
        irq_d && pin_q[0] |=> alert_oe)
        else $error("alert pin not driven");

    a_step_bound: assert property (@(posedge clk) disable iff (!rst_n) // see R01
        32'(tick_q) < STEP_CYCLES && $rose(cnt_q[0]) |-> $past(step_done))
        else $error("count advanced off a step");

    a_pulse_write: assert property (@(posedge clk) disable iff (!rst_n) // see R05
        wr && addr == 8'h7b |=> pulse_sel == $past(wdata))
        else $error("pulse register write lost");

    // register side effects, checked one cycle after their cause; the event check is same-cycle
    a_limit_write: assert property (@(posedge clk) disable iff (!rst_n) // see R01
        wr && addr == therm_cfg_pkg::OFS_DUR_LIMIT |=> limit_q == $past(wdata))
        else $error("limit register write lost");

    a_irq_level: assert property (@(posedge clk) disable iff (!rst_n) // see R02
        (status_q & ~mask_q) != therm_cfg_pkg::RST_ZERO |=> irq_q)
        else $error("unmasked status did not raise interrupt");

    a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n) // see R11
        !rd |=> rdata == therm_cfg_pkg::RST_ZERO)
        else $error("read data not zero outside read cycle");

    a_event_needs_active: assert property (@(posedge clk) disable iff (!rst_n) // see R13
        !active_q |-> !evt)
        else $error("duration event without active monitor");

    a_flag_read_clear: assert property (@(posedge clk) disable iff (!rst_n) // see R14
        timer_rd && !rise |=> !flag_q)
        else $error("assertion flag survived timer read");

    a_count_read_clear: assert property (@(posedge clk) disable iff (!rst_n) // see R14
        timer_rd |=> cnt_q == therm_cfg_pkg::RST_ZERO)
        else $error("timer count survived read");

    a_alert_meas_sel: assert property (@(posedge clk) disable iff (!rst_n) // see R06
        wr && addr == therm_cfg_pkg::OFS_PIN_CFG |=> meas_2v5_en == !$past(wdata[therm_cfg_pkg::ALERT_SEL_BIT]))
        else $error("2.5 V measurement select wrong");

    a_therm_meas_sel: assert property (@(posedge clk) disable iff (!rst_n) // see R07
        wr && addr == therm_cfg_pkg::OFS_PIN_CFG |=> meas_5v_en == !$past(wdata[therm_cfg_pkg::THERM_SEL_BIT]))
        else $error("5 V measurement select wrong");
endmodule

// ==== src/therm_cfg_pkg.sv ====
// Purpose: constants shared by the thermal-duration and fan pulse configuration bank
// Assumes: 25 MHz clock, 8-bit register port
// Notes:   offsets are byte addresses of the serial management register space
package therm_cfg_pkg;
    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_IRQ_STATUS2  = 8'h42;
    localparam logic [7:0] OFS_IRQ_MASK2    = 8'h75;
    localparam logic [7:0] OFS_CONFIG3      = 8'h78;
    localparam logic [7:0] OFS_TIMER_STATUS = 8'h79;
    localparam logic [7:0] OFS_DUR_LIMIT    = 8'h7a;
    localparam logic [7:0] OFS_PULSE_SEL    = 8'h7b;
    localparam logic [7:0] OFS_PIN_CFG      = 8'h7d;
    localparam logic [7:0] OFS_TEST_ONE     = 8'h7e;
    localparam logic [7:0] OFS_TEST_TWO     = 8'h7f;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_DUR_LIMIT = 8'h00;
    localparam logic [7:0] RST_PULSE_SEL = 8'h55;
    localparam logic [7:0] RST_PIN_CFG   = 8'h00;
    localparam logic [7:0] RST_CONFIG3   = 8'h00;
    localparam logic [7:0] RST_MASK2     = 8'h00;
    localparam logic [7:0] RST_ZERO      = 8'h00;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int TIMER_EVT_BIT    = 5;  // duration event in status 2 and mask 2
    localparam int THERM_EN_BIT     = 1;  // monitoring enable in config 3
    localparam int ALERT_SEL_BIT    = 0;  // alert_pin_select
    localparam int THERM_SEL_BIT    = 1;  // thermal_pin_select
    localparam int THRESH_LSB       = 2;  // tach_input_threshold, two bits
    localparam logic [7:0] PIN_CFG_WMASK = 8'h0f;
    localparam logic [7:0] MIN_REPORT    = 8'h02;  // count that equals 45.52 ms

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int STEP_NS       = 22_760_000;  // 22.76 ms per count
    localparam int STEP_CYCLES   = STEP_NS / CLK_PERIOD_NS;
    localparam int TICK_W        = 20;
endpackage

// ==== dv/host_model.sv ====
// Purpose: management host driving the register port of the configuration bank
// Assumes: one-cycle strobes, read data stands in the cycle after the read strobe
// Notes:   gap adds idle cycles before each access to act as a slow host
module host_model (
    input  wire logic       clk,    // bus clock
    output logic      [7:0] addr,   // register address
    output logic      [7:0] wdata,  // write data
    output logic            wr,     // write strobe
    output logic            rd,     // read strobe
    input  wire logic [7:0] rdata   // read data
);
    timeunit 1ns;
    timeprecision 1ns;
    int gap = 0;

    // idle bus at time zero
    initial begin
        addr  = 8'h00;
        wdata = 8'h00;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    // one-cycle write; test registers are left alone unless misuse is asked for
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input bit misuse = 0);
        if (!misuse && a[7:1] == 7'h3f) return;
        repeat (gap) @(posedge clk);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        wdata <= ~d;  // released data must not look valid
    endtask

    // one-cycle read, data taken once the taking edge has settled
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
endmodule

// ==== dv/tb.sv ====
// Purpose: self-checking bench for the thermal limit and fan pulse bank
// Assumes: count step shortened to 16 cycles
// Notes:   thermal pins are driven here, register traffic by the host model
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int STEP = 16;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       therm_5v_n = 1'b1;
    logic       tach4_n = 1'b1;
    logic [7:0] addr, wdata, rdata, pulse_sel;
    logic       wr, rd, irq, alert_oe, meas_2v5_en, meas_5v_en;
    logic [1:0] tach_thresh;
    int         failures = 0;
    int         samples_checked = 0;

    always #20 clk = ~clk;

    therm_limit_fan_pulse_config #(.STEP_CYCLES(STEP)) dut_u (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .therm_5v_n(therm_5v_n), .tach4_n(tach4_n), .irq(irq),
        .alert_oe(alert_oe), .pulse_sel(pulse_sel), .tach_thresh(tach_thresh),
        .meas_2v5_en(meas_2v5_en), .meas_5v_en(meas_5v_en));
    host_model host_u (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

    // ----------------------------------------------------------------
    // compare helpers
    // ----------------------------------------------------------------
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host_u.rd_reg(a, d);
        chk_val(d, exp);
    endtask
    // bounded wait, irq is registered so it trails its cause
    task automatic wait_irq(input logic exp, input int n);
        // look just after each edge so the flop has settled
        #1;
        for (int i = 0; i < n && irq !== exp; i++) begin
            @(posedge clk);
            #1;
        end
        chk_bit(irq, exp);
    endtask
    task automatic complete_run;
        if (failures == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        $display("Error at %0t: watchdog expired", $time);
        complete_run();
    end

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] v;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(8'h7a, 8'h00);
        rd_chk(8'h7b, 8'h55);
        rd_chk(8'h7d, 8'h00);
        chk_val(pulse_sel, 8'h55);
        chk_bit(meas_5v_en, 1'b1);
        // distinct code per fan so a swapped field shows up
        for (int c = 0; c < 4; c++) begin
            v = {2'(c + 3), 2'(c + 2), 2'(c + 1), 2'(c)};
            host_u.wr_reg(8'h7b, v);
            rd_chk(8'h7b, v);
            chk_val(pulse_sel, v);
            host_u.wr_reg(8'h7d, {4'hf, 2'(c), 2'(c)});
            rd_chk(8'h7d, {4'h0, 2'(c), 2'(c)});
            chk_val({6'h00, tach_thresh}, 8'(c));
            chk_bit(meas_2v5_en, ~c[0]);
            chk_bit(meas_5v_en, ~c[1]);
        end
        host_u.gap = 3;
        host_u.wr_reg(8'h7e, 8'ha5, 1);
        host_u.wr_reg(8'h7f, 8'h5a, 1);
        rd_chk(8'h7e, 8'h00);
        rd_chk(8'h7f, 8'h00);
        rd_chk(8'h10, 8'h00);
        host_u.gap = 0;
        host_u.wr_reg(8'h7a, 8'hff);
        rd_chk(8'h7a, 8'hff);
        // limit zero, 5 V pin as thermal input, alert routed out
        host_u.wr_reg(8'h7a, 8'h00);
        host_u.wr_reg(8'h78, 8'h02);
        host_u.wr_reg(8'h7d, 8'h03);
        host_u.rd_reg(8'h79, v);
        @(posedge clk) therm_5v_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1 chk_bit(irq, 1'b0);
        wait_irq(1'b1, 6);
        chk_bit(alert_oe, 1'b1);
        rd_chk(8'h42, 8'h20);
        rd_chk(8'h79, 8'h01);
        @(posedge clk) therm_5v_n <= 1'b1;
        host_u.wr_reg(8'h42, 8'h20);
        wait_irq(1'b0, 4);
        chk_bit(alert_oe, 1'b0);
        // limit three: event only once the count passes it
        host_u.wr_reg(8'h7a, 8'h03);
        host_u.wr_reg(8'h7d, 8'h02);
        host_u.rd_reg(8'h79, v);
        @(posedge clk) therm_5v_n <= 1'b0;
        repeat (50) @(posedge clk);
        #1 chk_bit(irq, 1'b0);
        wait_irq(1'b1, 40);
        chk_bit(alert_oe, 1'b0);
        rd_chk(8'h79, 8'h04);
        @(posedge clk) therm_5v_n <= 1'b1;
        host_u.wr_reg(8'h42, 8'h20);
        wait_irq(1'b0, 4);
        // monitoring off, then pin not selected
        host_u.wr_reg(8'h7a, 8'h00);
        host_u.wr_reg(8'h78, 8'h00);
        @(posedge clk) therm_5v_n <= 1'b0;
        repeat (20) @(posedge clk);
        rd_chk(8'h42, 8'h00);
        // deselect the low 5 V pin first so enabling never sees it
        host_u.wr_reg(8'h7d, 8'h00);
        host_u.wr_reg(8'h78, 8'h02);
        repeat (20) @(posedge clk);
        rd_chk(8'h42, 8'h00);
        // tach 4 pin as thermal input with the event masked
        host_u.wr_reg(8'h75, 8'h20);
        @(posedge clk) tach4_n <= 1'b0;
        repeat (20) @(posedge clk);
        #1 chk_bit(irq, 1'b0);
        rd_chk(8'h42, 8'h20);
        host_u.wr_reg(8'h75, 8'h00);
        wait_irq(1'b1, 4);
        complete_run();
    end
endmodule
